//--- verification/lmr_host.sv
`timescale 1ns/1ps
// Host model: one-cycle write strobe; read data taken one edge after the address
module lmr_host (
    input  wire logic        clk_sys, // Clock
    output lmr_pkg::lmr_wr_t wr_in,   // Write bundle
    output logic [7:0]       rd_addr, // Read address
    input  wire logic [7:0]  rd_data  // Read data
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1 wr_in = '{wr: 1'b1, addr: a, data: d};
        @(posedge clk_sys) #1 wr_in.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys) #1 rd_addr = a;
        @(posedge clk_sys) #1 d = rd_data;
    endtask
    initial {wr_in, rd_addr} = '0;
endmodule // lmr_host

//--- verification/lmr_regs_asserts.sv
`timescale 1ns/1ps
// Port timing checks of the register bank
module lmr_regs_asserts (
    input wire logic              clk_sys,       // Clock
    input wire logic              rst_b,         // Reset
    input wire lmr_pkg::lmr_wr_t  wr_in,         // Write
    input wire logic [7:0]        rd_addr,       // Read address
    input wire logic [7:0]        rd_data,       // Read data
    input wire logic              thermal_fault, // Fault
    input wire lmr_pkg::lmr_ctl_t ctl_out,       // Controls
    input wire logic [15:0]       rise_cycles    // Rise count
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Source writes; the quiet cycle after lets the control copy follow
    wire logic [2:0] st = wr_in.data[5:3];
    wire logic [2:0] bu = wr_in.data[2:0];
    wire logic       ws = wr_in.wr && wr_in.addr == 8'h08 && !thermal_fault;
    fault_clr_a: assert property (thermal_fault ##1 rd_addr == 8'h08
        |=> rd_data[5:0] == 6'h00) else $error("fault kept source");
    ramp_zero_a: assert property (rd_addr == 8'h0B |=> !rd_data[7] && !rd_data[3])
        else $error("ramp spare bit set");
    rise_map_a: assert property ($past(rst_b)
        |-> rise_cycles == 16'(lmr_pkg::RAMP_US[ctl_out.burst_rise_time] * 50)) else $error("rise");
    st_force_a: assert property (ws && st > 3'h4 ##1 !wr_in.wr |=> ctl_out.steady_on)
        else $error("steady not forced");
    bu_force_a: assert property (ws && bu > 3'h4 ##1 !wr_in.wr |=> ctl_out.burst_on)
        else $error("burst not forced");
    st_off_a: assert property (ws && st == 3'h0 ##1 !wr_in.wr |=> !ctl_out.steady_on)
        else $error("steady not off");
    bu_off_a: assert property (ws && bu == 3'h0 ##1 !wr_in.wr |=> !ctl_out.burst_on)
        else $error("burst not off");
    pd_follow_a: assert property (ws ##1 !wr_in.wr |=>
        {ctl_out.lamp_request_pulldown, ctl_out.strobe_pulldown} == $past(wr_in.data[7:6], 2))
        else $error("pulldown");
endmodule // lmr_regs_asserts
bind lmr_regs lmr_regs_asserts lmr_regs_asserts_i (.*);

//--- verification/tb.sv
`timescale 1ns/1ps
// Register bank bench: host port calls against worked-out results
module tb;
    logic              clk_sys = 1'b0, rst_b = 1'b0;
    logic              undervoltage_lockout = 1'b0, thermal_fault = 1'b0;
    logic              overvoltage_fault = 1'b0, lamp_request_pin = 1'b0, strobe_pin = 1'b0;
    logic              radio_limit_a_input = 1'b0, radio_limit_b_input = 1'b0;
    logic [5:0]        burst_current_prog = 6'h3F;
    logic [7:0]        rd_addr, rd_data, rv, t;
    logic [15:0]       rise_cycles, fall_cycles;
    lmr_pkg::lmr_wr_t  wr_in;
    lmr_pkg::lmr_ctl_t ctl_out;
    int                n_fail = 0, checks = 0, cyc = 0;
    lmr_regs lmr_regs_i (.*);
    lmr_host lmr_host_i (.*);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        n_fail += int'(got !== exp);
        if (got !== exp)
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        lmr_host_i.rd(a, rv);
        chk(rv, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic give_verdict(input int extra);
        n_fail += extra;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Clock, and a cycle ceiling well above the run length
    initial forever #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        if (cyc++ == 2000)
            give_verdict(1);
    initial
    begin
        repeat (20) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        for (int a = 8; a < 13; a++)
            rchk(8'(a), (a > 10) ? 8'h00 : 8'hC0);
        lmr_host_i.wr(8'h0B, 8'hFF);
        rchk(8'h0B, 8'h77);
        chk(fall_cycles, 16'(32896 * 50));
        chk(rise_cycles, 16'(32896 * 50));
        chk({ctl_out.burst_rise_time, ctl_out.burst_fall_time}, 6'h3F);
        // Every source code against every pin pair, pull-downs swept too
        for (int i = 0; i < 32; i++)
        begin
            lmr_host_i.wr(8'h08, {i[1:0], i[4:2], ~i[4:2]});
            {lamp_request_pin, strobe_pin} = i[1:0];
            t = {3'h7, i[1] & i[0], i[1] | i[0], i[0], i[1], 1'b0};
            settle(4);
            chk(ctl_out.steady_on, t[i[4:2]]);
            chk(ctl_out.burst_on, t[~i[4:2]]);
            chk({ctl_out.lamp_request_pulldown, ctl_out.strobe_pulldown}, i[1:0]);
        end
        // Each fault clears the source fields only
        for (int f = 0; f < 3; f++)
        begin
            lmr_host_i.wr(8'h08, 8'hFF);
            settle(1);
            {undervoltage_lockout, thermal_fault, overvoltage_fault} = 3'(1 << f);
            settle(1);
            {undervoltage_lockout, thermal_fault, overvoltage_fault} = 3'h0;
            rchk(8'h08, 8'hC0);
            rchk(8'h0B, 8'h77);
        end
        // Lower cap wins while both events are present
        lmr_host_i.wr(8'h09, 8'hD0);
        lmr_host_i.wr(8'h0A, 8'hC8);
        {radio_limit_a_input, radio_limit_b_input} = 2'b11;
        settle(4);
        chk(ctl_out.burst_current, 6'h08);
        // A disabled event no longer caps
        lmr_host_i.wr(8'h0A, 8'h00);
        settle(2);
        chk(ctl_out.burst_current, 6'h10);
        chk({ctl_out.radio_limit_a_pulldown, ctl_out.radio_limit_b_pulldown}, 2'b10);
        // A program below the cap wins; a zero cap is a real step; a disabled A no longer caps
        burst_current_prog = 6'h05;
        settle(2);
        chk(ctl_out.burst_current, 6'h05);
        lmr_host_i.wr(8'h09, 8'hC0);
        settle(2);
        chk(ctl_out.burst_current, 6'h00);
        lmr_host_i.wr(8'h09, 8'h40);
        settle(2);
        chk(ctl_out.burst_current, 6'h05);
        // Supply undervoltage in mid-run restores every register
        rst_b = 1'b0;
        settle(2);
        rst_b = 1'b1;
        for (int a = 8; a < 12; a++)
            rchk(8'(a), (a > 10) ? 8'h00 : 8'hC0);
        give_verdict(0);
    end
endmodule // tb

//--- verilog/lmr_pkg.sv
package lmr_pkg;

    // Register offsets
    localparam logic [7:0] OFS_SOURCE   = 8'h08;
    localparam logic [7:0] OFS_LIMIT_A  = 8'h09;
    localparam logic [7:0] OFS_LIMIT_B  = 8'h0A;
    localparam logic [7:0] OFS_RAMP     = 8'h0B;

    // Reset values
    localparam logic [7:0] RST_SOURCE   = 8'hC0;
    localparam logic [7:0] RST_LIMIT    = 8'hC0;
    localparam logic [7:0] RST_RAMP     = 8'h00;
    localparam logic [7:0] RAMP_MASK    = 8'h77;

    // Field positions
    localparam int BIT_PD_LAMP   = 7;
    localparam int BIT_PD_STROBE = 6;
    localparam int BIT_LIM_ON    = 7;
    localparam int BIT_LIM_PD    = 6;
    localparam int POS_STEADY    = 3;
    localparam int POS_BURST     = 0;
    localparam int POS_RISE      = 4;
    localparam int POS_FALL      = 0;

    // Source select codes
    localparam logic [2:0] SRC_OFF    = 3'h0;
    localparam logic [2:0] SRC_LAMP   = 3'h1;
    localparam logic [2:0] SRC_STROBE = 3'h2;
    localparam logic [2:0] SRC_OR     = 3'h3;
    localparam logic [2:0] SRC_AND    = 3'h4;

    // Ramp times in microseconds, code 0 to 7
    localparam int RAMP_US [8] = '{384, 640, 1152, 2176, 4224, 8320, 16512, 32896};
    localparam int CLK_MHZ     = 50;

    // Register write strobe bundle
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } lmr_wr_t;

    // Derived control outputs
    typedef struct packed {
        logic       steady_on;
        logic       burst_on;
        logic       lamp_request_pulldown;
        logic       strobe_pulldown;
        logic       radio_limit_a_pulldown;
        logic       radio_limit_b_pulldown;
        logic [5:0] burst_current;
        logic [2:0] burst_rise_time;
        logic [2:0] burst_fall_time;
    } lmr_ctl_t;

endpackage

//--- verilog/lmr_regs.sv
`timescale 1ns/1ps

module lmr_regs (
    input  wire logic              clk_sys,          // 50 MHz system clock
    input  wire logic              rst_b,            // Async reset, supply undervoltage
    input  wire lmr_pkg::lmr_wr_t  wr_in,            // Register write from serial slave
    input  wire logic [7:0]        rd_addr,          // Register read address
    output logic [7:0]             rd_data,          // Registered read data
    input  wire logic              undervoltage_lockout, // Lockout event, same clock
    input  wire logic              thermal_fault,    // Thermal event, same clock
    input  wire logic              overvoltage_fault, // Overvoltage event, same clock
    input  wire logic              lamp_request_pin, // Lamp request pin, async
    input  wire logic              strobe_pin,       // Strobe pin, async
    input  wire logic              radio_limit_a_input, // First transmit event pin, async
    input  wire logic              radio_limit_b_input, // Second transmit event pin, async
    input  wire logic [5:0]        burst_current_prog, // Programmed burst current code
    output lmr_pkg::lmr_ctl_t      ctl_out,          // Registered control outputs
    output logic [15:0]            rise_cycles,      // Rise time in clock cycles
    output logic [15:0]            fall_cycles       // Fall time in clock cycles
);

    // Register bank, synchroniser stages and output flops
    logic [7:0] source_r;
    logic [7:0] limit_a_r;
    logic [7:0] limit_b_r;
    logic [7:0] ramp_r;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [7:0] rd_data_r;
    lmr_pkg::lmr_ctl_t ctl_r;
    logic [15:0] rise_r;
    logic [15:0] fall_r;

    // Pins pass two flops; only the second stage is read. The first stage may go
    // metastable on a pin edge, so no logic other than the second stage looks at it.
    wire [3:0] pins_raw = {radio_limit_b_input, radio_limit_a_input, strobe_pin,
                           lamp_request_pin};
    wire lamp_s   = sync2_r[0];
    wire strobe_s = sync2_r[1];
    wire lim_a_s  = sync2_r[2];
    wire lim_b_s  = sync2_r[3];

    // Write decode; writes to offsets outside the bank match nothing and are dropped,
    // which keeps the neighbouring registers safe from stray strobes
    wire wr_src  = wr_in.wr && (wr_in.addr == lmr_pkg::OFS_SOURCE);
    wire wr_lima = wr_in.wr && (wr_in.addr == lmr_pkg::OFS_LIMIT_A);
    wire wr_limb = wr_in.wr && (wr_in.addr == lmr_pkg::OFS_LIMIT_B);
    wire wr_ramp = wr_in.wr && (wr_in.addr == lmr_pkg::OFS_RAMP);
    wire fault   = undervoltage_lockout || thermal_fault || overvoltage_fault;
    // The fault inputs are levels from the protection logic on this clock, so they
    // are read with no synchroniser; a fault held for many cycles keeps both mode
    // fields at zero, and a host write during it lands only in the pull-down bits.
    // Supply undervoltage is not here: it is the asynchronous reset of the whole bank.

    // Next source register; a fault beats a same-cycle write so no mode survives a fault
    // A write that lands in the same cycle still sets the pull-down bits, since the
    // fault clear covers only the two mode fields.
    wire [7:0] src_wr  = wr_src ? wr_in.data : source_r;
    wire [7:0] src_nxt = fault ? {src_wr[7:6], 6'h00} : src_wr;
    // The mask keeps only the two three-bit ramp fields
    // unused ramp bits dropped
    wire [7:0] ramp_nxt = wr_ramp ? (wr_in.data & lmr_pkg::RAMP_MASK) : ramp_r;

    // Source decode shared by steady and burst fields. One decoder for both means the
    // two fields can never disagree on what a code does; codes 101 to 111 all fall to
    // the default branch and force the light on whatever the pins show.
    function automatic logic src_dec(input logic [2:0] code, input logic a, input logic b);
        logic r;
        r = 1'b1;
        case (code)
            lmr_pkg::SRC_OFF:    r = 1'b0;
            lmr_pkg::SRC_LAMP:   r = a;
            lmr_pkg::SRC_STROBE: r = b;
            lmr_pkg::SRC_OR:     r = a | b;
            lmr_pkg::SRC_AND:    r = a & b;
            default:             r = 1'b1;
        endcase
        return r;
    endfunction

    // Ramp code to cycle count, rounded up to whole microseconds of the clock.
    // Only the low sixteen bits are kept: codes 011 to 111 wrap, so a consumer that
    // needs the five longest ramps must use the code itself, not this count.
    function automatic logic [15:0] ramp_cyc(input logic [2:0] code);
        return 16'(((lmr_pkg::RAMP_US[code] * lmr_pkg::CLK_MHZ) + 49) / 50 * 50);
    endfunction

    // Field extraction; the pins reach the decode only through the second sync stage,
    // so a pin change shows on the outputs three edges later
    wire [2:0] steady_code = source_r[lmr_pkg::POS_STEADY +: 3];
    wire [2:0] burst_code  = source_r[lmr_pkg::POS_BURST +: 3];
    wire steady_nxt = src_dec(steady_code, lamp_s, strobe_s);
    wire burst_nxt  = src_dec(burst_code, lamp_s, strobe_s);

    // An event counts only while its enable bit is set; the pin alone does nothing
    // limit A gated by enable
    wire lim_a_act = limit_a_r[lmr_pkg::BIT_LIM_ON] && lim_a_s;
    wire lim_b_act = limit_b_r[lmr_pkg::BIT_LIM_ON] && lim_b_s;
    // cap A; code zero still a current step
    wire [5:0] cap_a = limit_a_r[5:0];
    wire [5:0] cap_b = limit_b_r[5:0];
    // The caps chain through one compare each rather than a sorted pick; a plain
    // numeric compare is enough because every current field shares one step scale
    // with zero as its lowest step. A disabled event leaves the program untouched.
    // minimum of program and active caps
    wire [5:0] cur_a   = (lim_a_act && cap_a < burst_current_prog) ? cap_a
                                                                    : burst_current_prog;
    wire [5:0] cur_nxt = (lim_b_act && cap_b < cur_a) ? cap_b : cur_a;

    // Read mux; unmapped offsets read zero, so a host scan of the map sees no
    // stale value from an earlier read
    logic [7:0] rd_nxt;
    always_comb
    begin
        rd_nxt = 8'h00;
        if (rd_addr == lmr_pkg::OFS_SOURCE)
        begin
            rd_nxt = source_r;
        end
        else if (rd_addr == lmr_pkg::OFS_LIMIT_A)
        begin
            rd_nxt = limit_a_r;
        end
        else if (rd_addr == lmr_pkg::OFS_LIMIT_B)
        begin
            rd_nxt = limit_b_r;
        end
        else if (rd_addr == lmr_pkg::OFS_RAMP)
        begin
            rd_nxt = ramp_r;
        end
    end

    lmr_pkg::lmr_ctl_t ctl_nxt;
    // Control bundle assembly
    // The bundle starts from zero so that a field added later cannot be left floating
    always_comb
    begin
        ctl_nxt                        = '0;
        ctl_nxt.steady_on              = steady_nxt;
        ctl_nxt.burst_on               = burst_nxt;
        ctl_nxt.lamp_request_pulldown  = source_r[lmr_pkg::BIT_PD_LAMP];
        ctl_nxt.strobe_pulldown        = source_r[lmr_pkg::BIT_PD_STROBE];
        ctl_nxt.radio_limit_a_pulldown = limit_a_r[lmr_pkg::BIT_LIM_PD];
        ctl_nxt.radio_limit_b_pulldown = limit_b_r[lmr_pkg::BIT_LIM_PD];
        // Capped current follows the events with the pins' latency
        ctl_nxt.burst_current          = cur_nxt;
        ctl_nxt.burst_rise_time        = ramp_r[lmr_pkg::POS_RISE +: 3];
        ctl_nxt.burst_fall_time        = ramp_r[lmr_pkg::POS_FALL +: 3];
    end

    // Limit registers take whole bytes: enable, pull-down and a six-bit cap, no spare
    wire [7:0] limit_a_nxt = wr_lima ? wr_in.data : limit_a_r;
    wire [7:0] limit_b_nxt = wr_limb ? wr_in.data : limit_b_r;

    // Source select register. Faults reach it only through src_nxt, as a synchronous
    // clear, so the asynchronous reset stays reserved for supply undervoltage.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            source_r <= lmr_pkg::RST_SOURCE;
        end
        else
        begin
            source_r <= src_nxt;
        end
    end

    // First limit register; cleared by supply undervoltage only, never by a fault,
    // so a radio event that trips a fault still finds its cap in place afterwards
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            limit_a_r <= lmr_pkg::RST_LIMIT;
        end
        else
        begin
            limit_a_r <= limit_a_nxt;
        end
    end

    // Second limit register; same reset scope as the first
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            limit_b_r <= lmr_pkg::RST_LIMIT;
        end
        else
        begin
            limit_b_r <= limit_b_nxt;
        end
    end

    // Ramp register; the spare bits are masked before the flop, so they cannot
    // read back set even for a moment after a write
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ramp_r <= lmr_pkg::RST_RAMP;
        end
        else
        begin
            ramp_r <= ramp_nxt;
        end
    end

    // Two-flop synchroniser for the four pins; reset low, which is the idle level
    // that the pull-downs give, so no false request follows a reset
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end
        else
        begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
        end
    end

    // Read data flop; a read answers one edge after the address
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_data_r <= 8'h00;
        end
        else
        begin
            rd_data_r <= rd_nxt;
        end
    end

    // Control flop; every control output leaves the block from here
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_r <= '0;
        end
        else
        begin
            ctl_r <= ctl_nxt;
        end
    end

    // Ramp counts follow the same edge as the ramp codes in the control bundle
    wire [15:0] rise_nxt = ramp_cyc(ctl_nxt.burst_rise_time);
    wire [15:0] fall_nxt = ramp_cyc(ctl_nxt.burst_fall_time);
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rise_r <= 16'h0000;
            fall_r <= 16'h0000;
        end
        else
        begin
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
        end
    end

    // Every output is a flop copy, so nothing combinational reaches a pin
    assign rd_data     = rd_data_r;
    assign ctl_out     = ctl_r;
    assign rise_cycles = rise_r;
    assign fall_cycles = fall_r;

endmodule // lmr_regs
